// ===== verilog/fdl_pkg.sv
package fdl_pkg;
   // Register indices; the byte address is four times the index.
   localparam logic [7:0] IDX_RX_CODE = 8'h04;
   localparam logic [7:0] IDX_RX_FIFO = 8'h05;
   localparam logic [7:0] IDX_TX_STAT = 8'h06;
   localparam logic [7:0] IDX_TX_CODE = 8'h07;
   localparam logic [7:0] IDX_TX_FIFO = 8'h08;
   localparam logic [7:0] IDX_LEG_BYTE = 8'h28;
   localparam logic [7:0] IDX_MATCH_ONE = 8'h29;
   localparam logic [7:0] IDX_MATCH_TWO = 8'h2a;
   localparam logic [7:0] IDX_LEG_STAT = 8'h30;
   localparam logic [7:0] IDX_LEG_MASK = 8'h31;
   localparam logic [7:0] IDX_LEG_CTRL = 8'h32;
   localparam int ADDR_W = 10;

   // Field positions.
   localparam int RX_LATCHED_BIT = 7;
   localparam int RX_LIVE_BIT = 6;
   localparam int TX_SEND_BIT = 7;
   localparam int TX_SRC_BIT = 6;
   localparam int TX_EMPTY_BIT = 2;
   localparam int TX_FULL_BIT = 1;
   localparam int TX_UNDERRUN_BIT = 0;
   localparam int LEG_FULL_BIT = 4;
   localparam int LEG_MATCH_BIT = 2;
   localparam int LEG_DESTUFF_BIT = 0;

   // Reset values and sizes.
   localparam logic [5:0] CODE_RESET = 6'h3f;
   localparam int CODE_W = 6;
   localparam int BYTE_W = 8;
   localparam logic [3:0] ABORT_ONES = 4'h8;
   localparam logic [2:0] STUFF_RUN = 3'h5;
   localparam logic [2:0] RUN_MAX = 3'h6;

   // Timing of the link; the bench does not use it and paces strobes every four clocks.
   localparam int CLK_PERIOD_NS = 100;
   localparam int LINK_BIT_TIME_US = 250;
   localparam int LINK_BIT_CYCLES = (LINK_BIT_TIME_US * 1000) / CLK_PERIOD_NS;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Verified receive code from the code detector.
   typedef struct packed {
      logic valid;
      logic live;
      logic [5:0] code;
   } fdl_rx_code_t;

   // Live view of the HDLC transmit FIFO.
   typedef struct packed {
      logic full;
      logic empty;
      logic underrun;
   } fdl_tx_fifo_t;
endpackage

// ===== verilog/fdl_link_controller.sv
`timescale 1ns/100ps
// Operation
// - Receive code register holds latched code-detected copy, cleared by reading it.
// - Received codeword is six bits, bit 0 first received, bit 5 last.
// - Received code shows last verified code; resets to all ones.
// - Both HDLC FIFO data registers carry one byte, bit 7 most significant.
// - Transmit status shows live FIFO full and empty flags.
// - Unintended FIFO empty sends abort and sets latched underrun, cleared on read.
// - Transmit status bits 7 to 3 are unassigned, any read value.
// - Outgoing six-bit codeword is sent bit 0 first, bit 5 last.
// - Legacy mode shifts each link bit into eight-bit register, byte per 2 ms.
// - Full legacy register sets buffer-full status; masked interrupt goes low.
// - Received byte equal to either match byte sets match status and interrupt.
// - With destuff enabled, a zero after exactly five ones is deleted.
// - A zero after six or more ones is kept.
// - Legacy register holds first received bit in least significant position.
// - Legacy shifter and HDLC or code path take the same receive bits together.
// - Only one internal source drives the outgoing link bits at a time.
module fdl_link_controller (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // AXI4-Lite write address and data
   input wire logic [fdl_pkg::ADDR_W-1:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   // AXI4-Lite read
   input wire logic [fdl_pkg::ADDR_W-1:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   // Receive data link from the framer
   input wire logic i_rx_link_bit,
   input wire logic i_rx_link_strobe,
   input wire fdl_pkg::fdl_rx_code_t i_rx_code,
   // HDLC controller FIFO side
   input wire logic [7:0] i_rx_fifo_data,
   output logic o_rx_fifo_pop,
   input wire fdl_pkg::fdl_tx_fifo_t i_tx_fifo,
   output logic [7:0] o_tx_fifo_data,
   output logic o_tx_fifo_push,
   input wire logic i_hdlc_tx_bit,
   // Transmit data link toward the framer
   input wire logic i_tx_link_input_pin,
   input wire logic i_tx_link_strobe,
   output logic o_tx_link_bit,
   output logic o_rx_to_hdlc_bit,
   output logic o_rx_to_hdlc_strobe,
   // Interrupt
   output logic o_link_int_n
);

   // Write channel state.
   logic aw_got_ff;
   logic w_got_ff;
   logic [fdl_pkg::ADDR_W-1:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic awready_ff;
   logic wready_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   // Read channel state.
   logic arready_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic rx_pop_ff;
   // Registers.
   logic [5:0] rx_code_ff;
   logic rx_latched_ff;
   logic underrun_ff;
   logic send_code_ff;
   logic src_sel_ff;
   logic [5:0] tx_code_ff;
   logic [7:0] tx_fifo_data_ff;
   logic tx_push_ff;
   logic [7:0] leg_byte_ff;
   logic [7:0] match_one_ff;
   logic [7:0] match_two_ff;
   logic leg_full_ff;
   logic leg_match_ff;
   logic leg_full_mask_ff;
   logic leg_match_mask_ff;
   logic destuff_en_ff;
   // Legacy receive path.
   logic [7:0] shift_ff;
   logic [2:0] bit_cnt_ff;
   logic [2:0] ones_run_ff;
   // Transmit path.
   logic [2:0] code_pos_ff;
   logic [3:0] abort_cnt_ff;
   logic tx_bit_ff;
   logic pin_meta_ff;
   logic pin_sync_ff;
   logic int_n_ff;
   logic hdlc_bit_ff;
   logic hdlc_stb_ff;

   logic wr_go;
   logic rd_go;
   logic [7:0] wr_idx;
   logic [7:0] rd_idx;
   logic leg_take;
   logic leg_drop;
   logic [7:0] nxt_shift;
   logic byte_done;

   // Address bits 1:0 are ignored; only listed indices decode to a register.
   function automatic logic [7:0] word_index(input logic [fdl_pkg::ADDR_W-1:0] addr);
      word_index = addr[fdl_pkg::ADDR_W-1:2];
   endfunction

   function automatic logic is_mapped(input logic [7:0] idx);
      case (idx)
         fdl_pkg::IDX_RX_CODE, fdl_pkg::IDX_RX_FIFO, fdl_pkg::IDX_TX_STAT,
         fdl_pkg::IDX_TX_CODE, fdl_pkg::IDX_TX_FIFO, fdl_pkg::IDX_LEG_BYTE,
         fdl_pkg::IDX_MATCH_ONE, fdl_pkg::IDX_MATCH_TWO, fdl_pkg::IDX_LEG_STAT,
         fdl_pkg::IDX_LEG_MASK, fdl_pkg::IDX_LEG_CTRL: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   assign wr_go = aw_got_ff && w_got_ff && !bvalid_ff;
   assign rd_go = i_arvalid && arready_ff;
   assign wr_idx = word_index(awaddr_ff);
   assign rd_idx = word_index(i_araddr);

   // Write address and data are taken in either order, one write at a time.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         awaddr_ff <= '0;
         wdata_ff <= 32'h0;
         wstrb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= fdl_pkg::RESP_OKAY;
      end else begin
         awready_ff <= !aw_got_ff && !(i_awvalid && awready_ff);
         wready_ff <= !w_got_ff && !(i_wvalid && wready_ff);
         if (i_awvalid && awready_ff) begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= i_awaddr;
         end
         if (i_wvalid && wready_ff) begin
            w_got_ff <= 1'b1;
            wdata_ff <= i_wdata;
            wstrb_ff <= i_wstrb;
         end
         if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= is_mapped(wr_idx) ? fdl_pkg::RESP_OKAY : fdl_pkg::RESP_SLVERR;
         end else if (bvalid_ff && i_bready) begin
            bvalid_ff <= 1'b0;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
         end
      end
   end

   // Software-written configuration.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         send_code_ff <= 1'b0;
         src_sel_ff <= 1'b0;
         tx_code_ff <= 6'h00;
         match_one_ff <= 8'h00;
         match_two_ff <= 8'h00;
         leg_full_mask_ff <= 1'b0;
         leg_match_mask_ff <= 1'b0;
         destuff_en_ff <= 1'b0;
         tx_fifo_data_ff <= 8'h00;
         tx_push_ff <= 1'b0;
      end else begin
         tx_push_ff <= 1'b0;
         if (wr_go && wstrb_ff[0]) begin
            case (wr_idx)
               fdl_pkg::IDX_TX_CODE: begin
                  send_code_ff <= wdata_ff[fdl_pkg::TX_SEND_BIT];
                  src_sel_ff <= wdata_ff[fdl_pkg::TX_SRC_BIT];
                  tx_code_ff <= wdata_ff[fdl_pkg::CODE_W-1:0];
               end
               fdl_pkg::IDX_TX_FIFO: begin
                  tx_fifo_data_ff <= wdata_ff[fdl_pkg::BYTE_W-1:0];
                  tx_push_ff <= 1'b1;
               end
               fdl_pkg::IDX_MATCH_ONE: match_one_ff <= wdata_ff[7:0];
               fdl_pkg::IDX_MATCH_TWO: match_two_ff <= wdata_ff[7:0];
               fdl_pkg::IDX_LEG_MASK: begin
                  leg_full_mask_ff <= wdata_ff[fdl_pkg::LEG_FULL_BIT];
                  leg_match_mask_ff <= wdata_ff[fdl_pkg::LEG_MATCH_BIT];
               end
               fdl_pkg::IDX_LEG_CTRL: destuff_en_ff <= wdata_ff[fdl_pkg::LEG_DESTUFF_BIT];
               default: begin
               end
            endcase
         end
      end
   end

   // Read data is captured when the address is taken, with its side effects.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0;
         rresp_ff <= fdl_pkg::RESP_OKAY;
         rx_pop_ff <= 1'b0;
      end else begin
         rx_pop_ff <= rd_go && (rd_idx == fdl_pkg::IDX_RX_FIFO);
         if (rd_go) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rresp_ff <= is_mapped(rd_idx) ? fdl_pkg::RESP_OKAY : fdl_pkg::RESP_SLVERR;
            rdata_ff <= 32'h0;
            case (rd_idx)
               fdl_pkg::IDX_RX_CODE: begin
                  rdata_ff[fdl_pkg::RX_LATCHED_BIT] <= rx_latched_ff;
                  rdata_ff[fdl_pkg::RX_LIVE_BIT] <= i_rx_code.live;
                  rdata_ff[5:0] <= rx_code_ff;
               end
               fdl_pkg::IDX_RX_FIFO: rdata_ff[7:0] <= i_rx_fifo_data;
               fdl_pkg::IDX_TX_STAT: begin
                  // Unassigned upper bits read as zero.
                  rdata_ff[fdl_pkg::TX_EMPTY_BIT] <= i_tx_fifo.empty;
                  rdata_ff[fdl_pkg::TX_FULL_BIT] <= i_tx_fifo.full;
                  rdata_ff[fdl_pkg::TX_UNDERRUN_BIT] <= underrun_ff;
               end
               fdl_pkg::IDX_TX_CODE: begin
                  rdata_ff[fdl_pkg::TX_SEND_BIT] <= send_code_ff;
                  rdata_ff[fdl_pkg::TX_SRC_BIT] <= src_sel_ff;
                  rdata_ff[5:0] <= tx_code_ff;
               end
               fdl_pkg::IDX_LEG_BYTE: rdata_ff[7:0] <= leg_byte_ff;
               fdl_pkg::IDX_MATCH_ONE: rdata_ff[7:0] <= match_one_ff;
               fdl_pkg::IDX_MATCH_TWO: rdata_ff[7:0] <= match_two_ff;
               fdl_pkg::IDX_LEG_STAT: begin
                  rdata_ff[fdl_pkg::LEG_FULL_BIT] <= leg_full_ff;
                  rdata_ff[fdl_pkg::LEG_MATCH_BIT] <= leg_match_ff;
               end
               fdl_pkg::IDX_LEG_MASK: begin
                  rdata_ff[fdl_pkg::LEG_FULL_BIT] <= leg_full_mask_ff;
                  rdata_ff[fdl_pkg::LEG_MATCH_BIT] <= leg_match_mask_ff;
               end
               fdl_pkg::IDX_LEG_CTRL: rdata_ff[fdl_pkg::LEG_DESTUFF_BIT] <= destuff_en_ff;
               default: rdata_ff <= 32'h0;
            endcase
         end else if (rvalid_ff && i_rready) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
         end else if (!rvalid_ff) begin
            arready_ff <= 1'b1;
         end
      end
   end

   // Receive code; a new event wins over the read that clears the latch.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rx_code_ff <= fdl_pkg::CODE_RESET;
         rx_latched_ff <= 1'b0;
      end else begin
         if (i_rx_code.valid) begin
            rx_code_ff <= i_rx_code.code;
         end
         if (i_rx_code.live) begin
            rx_latched_ff <= 1'b1;
         end else if (rd_go && rd_idx == fdl_pkg::IDX_RX_CODE) begin
            rx_latched_ff <= 1'b0;
         end
      end
   end

   // Underrun latch and abort length.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         underrun_ff <= 1'b0;
         abort_cnt_ff <= 4'h0;
      end else begin
         if (i_tx_fifo.underrun) begin
            underrun_ff <= 1'b1;
         end else if (rd_go && rd_idx == fdl_pkg::IDX_TX_STAT) begin
            underrun_ff <= 1'b0;
         end
         if (i_tx_fifo.underrun && src_sel_ff) begin
            abort_cnt_ff <= fdl_pkg::ABORT_ONES;
         end else if (i_tx_link_strobe && abort_cnt_ff != 4'h0) begin
            abort_cnt_ff <= abort_cnt_ff - 4'h1;
         end
      end
   end

   // The link pin comes from outside the clock domain.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         pin_meta_ff <= 1'b0;
         pin_sync_ff <= 1'b0;
      end else begin
         pin_meta_ff <= i_tx_link_input_pin;
         pin_sync_ff <= pin_meta_ff;
      end
   end

   // One source at a time feeds the outgoing link; code beats abort beats data.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         tx_bit_ff <= 1'b1;
         code_pos_ff <= 3'h0;
      end else begin
         if (!send_code_ff) begin
            code_pos_ff <= 3'h0;
         end
         if (i_tx_link_strobe) begin
            if (send_code_ff) begin
               tx_bit_ff <= tx_code_ff[code_pos_ff];
               code_pos_ff <= (code_pos_ff == 3'h5) ? 3'h0 : code_pos_ff + 3'h1;
            end else if (!src_sel_ff) begin
               tx_bit_ff <= pin_sync_ff;
            end else if (abort_cnt_ff != 4'h0) begin
               tx_bit_ff <= 1'b1;
            end else begin
               tx_bit_ff <= i_hdlc_tx_bit;
            end
         end
      end
   end

   // Destuffing: a zero after exactly five ones is dropped, after six kept.
   assign leg_drop = destuff_en_ff && !i_rx_link_bit &&
                     ones_run_ff == fdl_pkg::STUFF_RUN;
   assign leg_take = i_rx_link_strobe && !leg_drop;
   assign nxt_shift = {i_rx_link_bit, shift_ff[7:1]};
   assign byte_done = leg_take && bit_cnt_ff == 3'h7;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         shift_ff <= 8'h00;
         bit_cnt_ff <= 3'h0;
         ones_run_ff <= 3'h0;
         leg_byte_ff <= 8'h00;
      end else if (i_rx_link_strobe) begin
         if (!i_rx_link_bit) begin
            ones_run_ff <= 3'h0;
         end else if (ones_run_ff != fdl_pkg::RUN_MAX) begin
            ones_run_ff <= ones_run_ff + 3'h1;
         end
         if (leg_take) begin
            shift_ff <= nxt_shift;
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
         end
         if (byte_done) begin
            // An unread byte is overwritten here.
            leg_byte_ff <= nxt_shift;
         end
      end
   end

   // Legacy status, set over clear, masked onto the interrupt.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         leg_full_ff <= 1'b0;
         leg_match_ff <= 1'b0;
         int_n_ff <= 1'b1;
      end else begin
         if (byte_done) begin
            leg_full_ff <= 1'b1;
         end else if (rd_go && rd_idx == fdl_pkg::IDX_LEG_STAT) begin
            leg_full_ff <= 1'b0;
         end
         if (byte_done && (nxt_shift == match_one_ff || nxt_shift == match_two_ff)) begin
            leg_match_ff <= 1'b1;
         end else if (rd_go && rd_idx == fdl_pkg::IDX_LEG_STAT) begin
            leg_match_ff <= 1'b0;
         end
         int_n_ff <= !((leg_full_ff && leg_full_mask_ff) ||
                       (leg_match_ff && leg_match_mask_ff));
      end
   end

   // The HDLC receiver sees the same raw bits as the legacy shifter.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         hdlc_bit_ff <= 1'b0;
         hdlc_stb_ff <= 1'b0;
      end else begin
         hdlc_bit_ff <= i_rx_link_bit;
         hdlc_stb_ff <= i_rx_link_strobe;
      end
   end

   assign o_awready = awready_ff;
   assign o_wready = wready_ff;
   assign o_bvalid = bvalid_ff;
   assign o_bresp = bresp_ff;
   assign o_arready = arready_ff;
   assign o_rvalid = rvalid_ff;
   assign o_rdata = rdata_ff;
   assign o_rresp = rresp_ff;
   assign o_rx_fifo_pop = rx_pop_ff;
   assign o_tx_fifo_data = tx_fifo_data_ff;
   assign o_tx_fifo_push = tx_push_ff;
   assign o_tx_link_bit = tx_bit_ff;
   assign o_rx_to_hdlc_bit = hdlc_bit_ff;
   assign o_rx_to_hdlc_strobe = hdlc_stb_ff;
   assign o_link_int_n = int_n_ff;

endmodule // fdl_link_controller

// ===== verification/fdl_link_asserts.sv
`timescale 1ns/100ps
module fdl_link_asserts (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Register read channel
   input wire logic [fdl_pkg::ADDR_W-1:0] i_araddr,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic [31:0] o_rdata,
   // Link and FIFO side
   input wire logic i_rx_link_bit,
   input wire logic i_rx_link_strobe,
   input wire fdl_pkg::fdl_rx_code_t i_rx_code,
   input wire logic [7:0] i_rx_fifo_data,
   input wire logic o_rx_fifo_pop,
   input wire fdl_pkg::fdl_tx_fifo_t i_tx_fifo,
   input wire logic i_tx_link_strobe,
   input wire logic o_tx_link_bit,
   input wire logic o_rx_to_hdlc_bit,
   input wire logic o_rx_to_hdlc_strobe,
   input wire logic o_link_int_n
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   logic rd_take;
   assign rd_take = i_arvalid && o_arready;

   a_pop_pulse: assert property (rd_take && i_araddr == 10'h014
      |=> o_rx_fifo_pop ##1 !o_rx_fifo_pop) else $error("fifo pop is not one pulse");
   a_fifo_byte: assert property (rd_take && i_araddr == 10'h014
      |=> o_rdata == {24'h0, $past(i_rx_fifo_data)}) else $error("fifo byte wrong");
   a_live_flags: assert property (rd_take && i_araddr == 10'h018
      |=> o_rdata[2:1] == $past({i_tx_fifo.empty, i_tx_fifo.full}))
      else $error("fifo flags not live");
   a_stat_unused: assert property (rd_take && i_araddr == 10'h018
      |=> o_rdata[31:3] == 29'h0) else $error("unused status bits set");
   a_live_latch: assert property (rd_take && i_araddr == 10'h010 && i_rx_code.live
      && $past(i_rx_code.live) |=> o_rdata[7:6] == 2'h3)
      else $error("latched copy lost while live");
   a_rx_mirror: assert property (i_rx_link_strobe
      |=> o_rx_to_hdlc_strobe && o_rx_to_hdlc_bit == $past(i_rx_link_bit))
      else $error("receive bit not shared");
   a_tx_hold: assert property (!$past(i_tx_link_strobe) |-> $stable(o_tx_link_bit))
      else $error("link bit moved without strobe");
   a_int_cause: assert property ($fell(o_link_int_n) |-> $past(i_rx_link_strobe, 2))
      else $error("interrupt without a byte");

   cover property (o_rx_fifo_pop);
   cover property ($fell(o_link_int_n));
   cover property (rd_take && i_araddr == 10'h010 && i_rx_code.live);
endmodule // fdl_link_asserts

// ===== verification/fdl_far_end.sv
`timescale 1ns/100ps
module fdl_far_end (
   // Clock
   input wire logic i_clk,
   // Link toward the block
   input wire logic i_tx_bit,
   output logic o_rx_bit,
   output logic o_rx_strobe,
   output logic o_tx_strobe,
   // Last sixteen bits seen, newest at the top
   output logic [15:0] o_hist
);
   logic [1:0] div_ff = 2'h0;
   initial o_rx_bit = 1'b0;
   initial o_rx_strobe = 1'b0;
   initial o_tx_strobe = 1'b0;
   initial o_hist = 16'h0;

   // Outgoing bits are paced by a free strobe and sampled once settled.
   always @(posedge i_clk) begin
      div_ff <= div_ff + 2'h1;
      o_tx_strobe <= (div_ff == 2'h3);
      if (div_ff == 2'h1) o_hist <= {i_tx_bit, o_hist[15:1]};
   end

   // The line shows the inverse of the last bit once its strobe is gone.
   task send(input logic [15:0] bits, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge i_clk);
         o_rx_bit <= bits[i];
         o_rx_strobe <= 1'b1;
         @(posedge i_clk);
         o_rx_strobe <= 1'b0;
         o_rx_bit <= ~bits[i];
         repeat (2) @(posedge i_clk);
      end
   endtask
endmodule // fdl_far_end

// ===== verification/fdl_link_controller_tb.sv
`timescale 1ns/100ps
module fdl_link_controller_tb;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [9:0] awaddr = 10'h0;
   logic [9:0] araddr = 10'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic tx_pin = 1'b0, hdlc_bit = 1'b0;
   logic [7:0] fifo_in = 8'ha5;
   fdl_pkg::fdl_rx_code_t rx_code = 8'h0;
   fdl_pkg::fdl_tx_fifo_t tx_fifo = 3'b010;
   logic awready, wready, bvalid, arready, rvalid, pop, push, tx_bit, h_bit, h_stb, int_n;
   logic rx_bit, rx_stb, tx_stb;
   logic [1:0] bresp, rresp, bresp_l, rresp_l;
   logic [31:0] rdata, got;
   logic [7:0] push_data, pushed;
   logic [15:0] hist;
   int mismatches = 0;
   int compares = 0;

   initial forever #50 i_clk = ~i_clk;

   fdl_link_controller fdl_link_controller_inst (
      .i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
      .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
      .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
      .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
      .i_rready(rready), .i_rx_link_bit(rx_bit), .i_rx_link_strobe(rx_stb),
      .i_rx_code(rx_code), .i_rx_fifo_data(fifo_in), .o_rx_fifo_pop(pop),
      .i_tx_fifo(tx_fifo), .o_tx_fifo_data(push_data), .o_tx_fifo_push(push),
      .i_hdlc_tx_bit(hdlc_bit), .i_tx_link_input_pin(tx_pin), .i_tx_link_strobe(tx_stb),
      .o_tx_link_bit(tx_bit), .o_rx_to_hdlc_bit(h_bit), .o_rx_to_hdlc_strobe(h_stb),
      .o_link_int_n(int_n));

   fdl_far_end fdl_far_end_inst (.i_clk(i_clk), .i_tx_bit(tx_bit), .o_rx_bit(rx_bit),
      .o_rx_strobe(rx_stb), .o_tx_strobe(tx_stb), .o_hist(hist));

   always @(posedge i_clk) if (push === 1'b1) pushed <= push_data;

   task chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value at %0t: got %h, expected %h", $time, g, e);
      end
   endtask

   task wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge i_clk);
      awaddr <= a;
      wdata <= {24'h0, d};
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge i_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      bresp_l = bresp;
      bready <= 1'b0;
   endtask

   task rd(input logic [9:0] a);
      @(posedge i_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge i_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      got = rdata;
      rresp_l = rresp;
      rready <= 1'b0;
   endtask

   task rc(input logic [9:0] a, input logic [31:0] e);
      rd(a);
      chk(got, e);
   endtask

   // Sent code may start at any phase, so any rotation of it is accepted.
   function automatic logic isrot(input logic [5:0] v);
      logic [11:0] x;
      isrot = 1'b0;
      for (int i = 0; i < 6; i++) begin
         x = {6'h0b, 6'h0b} >> i;
         if (x[5:0] == v) isrot = 1'b1;
      end
   endfunction

   task close_out;
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge i_clk);
      mismatches++;
      close_out;
   end

   initial begin
      repeat (16) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (2) @(posedge i_clk);
      rc(10'h010, 32'h3f);
      @(posedge i_clk);
      rx_code <= 8'hd5;
      @(posedge i_clk);
      rx_code <= 8'h55;
      rc(10'h010, 32'hd5);
      rx_code <= 8'h15;
      rc(10'h010, 32'h95);
      rc(10'h010, 32'h15);
      rc(10'h014, 32'ha5);
      wr(10'h020, 8'hc3);
      repeat (2) @(posedge i_clk);
      chk({24'h0, pushed}, 32'hc3);
      tx_fifo <= 3'b100;
      rc(10'h018, 32'h02);
      tx_fifo <= 3'b010;
      rc(10'h018, 32'h04);
      wr(10'h3fc, 8'h01);
      chk({30'h0, bresp_l}, {30'h0, fdl_pkg::RESP_SLVERR});
      rc(10'h3fc, 32'h0);
      chk({30'h0, rresp_l}, {30'h0, fdl_pkg::RESP_SLVERR});
      wr(10'h01c, 8'hcb);
      rc(10'h01c, 32'hcb);
      repeat (72) @(posedge i_clk);
      chk({26'h0, hist[15:10]}, {26'h0, hist[9:4]});
      chk({31'h0, isrot(hist[15:10])}, 32'h1);
      wr(10'h01c, 8'h00);
      tx_pin <= 1'b1;
      repeat (72) @(posedge i_clk);
      chk({24'h0, hist[15:8]}, 32'hff);
      tx_pin <= 1'b0;
      repeat (72) @(posedge i_clk);
      chk({24'h0, hist[15:8]}, 32'h0);
      wr(10'h01c, 8'h40);
      tx_pin <= 1'b1;
      repeat (72) @(posedge i_clk);
      chk({16'h0, hist}, 32'h0);
      tx_fifo <= 3'b011;
      @(posedge i_clk);
      tx_fifo <= 3'b010;
      repeat (60) @(posedge i_clk);
      chk(32'($countones(hist)), 32'h8);
      rc(10'h018, 32'h05);
      rc(10'h018, 32'h04);
      wr(10'h0c8, 8'h01);
      wr(10'h0c4, 8'h14);
      wr(10'h0a4, 8'h7e);
      wr(10'h0a8, 8'h81);
      rc(10'h0a8, 32'h81);
      rc(10'h0c8, 32'h01);
      fdl_far_end_inst.send(16'h007e, 8);
      repeat (3) @(posedge i_clk);
      chk({31'h0, int_n}, 32'h0);
      rc(10'h0c0, 32'h14);
      rc(10'h0a0, 32'h7e);
      repeat (2) @(posedge i_clk);
      chk({31'h0, int_n}, 32'h1);
      fdl_far_end_inst.send(16'h005f, 9);
      repeat (3) @(posedge i_clk);
      rc(10'h0c0, 32'h10);
      rc(10'h0a0, 32'h3f);
      fdl_far_end_inst.send(16'h0081, 8);
      repeat (3) @(posedge i_clk);
      rc(10'h0c0, 32'h14);
      rc(10'h0a0, 32'h81);
      close_out;
   end
endmodule // fdl_link_controller_tb

bind fdl_link_controller fdl_link_asserts fdl_link_asserts_inst (.i_clk, .i_rst_n,
   .i_araddr, .i_arvalid, .o_arready, .o_rdata, .i_rx_link_bit, .i_rx_link_strobe,
   .i_rx_code, .i_rx_fifo_data, .o_rx_fifo_pop, .i_tx_fifo, .i_tx_link_strobe,
   .o_tx_link_bit, .o_rx_to_hdlc_bit, .o_rx_to_hdlc_strobe, .o_link_int_n);
